/* File: decr_host.sv */
`default_nettype none
module decr_host
    import decr_pkg::*;
(
    input  wire logic          clk,
    output decr_cfg_req_t      cfg_req,
    input  wire logic [15:0]   cfg_rdata,
    input  wire logic          cfg_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cfg_req = '0;

    // Released fields show the inverse so a design latching idle data is caught.
    task automatic access(input logic wr, input logic [7:0] off, input logic [15:0] wd,
                          output logic [15:0] rd, output logic ok);
        ok = 1'b0;
        rd = 16'h0000;
        @(negedge clk);
        cfg_req <= '{valid: 1'b1, write: wr, offset: off, wdata: wd};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            cfg_req <= '{valid: 1'b0, write: ~wr, offset: ~off, wdata: ~wd};
            if (cfg_ack === 1'b1) begin
                ok = 1'b1;
                rd = cfg_rdata;
            end
        end
    endtask : access
endmodule : decr_host
`default_nettype wire

/* File: decr_pkg.sv */
`default_nettype none
package decr_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_OFFSET       = 8'h04;
    localparam logic [7:0]  STS_OFFSET       = 8'h06;
    localparam logic [15:0] CMD_RESET        = 16'h0000;
    localparam logic [15:0] CMD_WRITE_MASK   = 16'h0546;
    localparam int          LEGACY_IRQ_OFF_B = 10;
    localparam int          FAST_B2B_EN_B    = 9;
    localparam int          SYS_ERR_REP_B    = 8;
    localparam int          PARITY_RESP_B    = 6;
    localparam int          SPECIAL_CYC_B    = 3;
    localparam int          BUS_MASTER_B     = 2;
    localparam int          MEM_SPACE_B      = 1;
    localparam int          IO_SPACE_B       = 0;
    localparam int          SIG_SYS_ERR_B    = 14;
    localparam int          MDI_ERR_B        = 8;
    localparam logic [2:0]  ERR_NONE         = 3'h0;
    localparam logic [3:0]  DESC_READ_ERR_CODE  = 4'h8;
    localparam logic [3:0]  DESC_WRITE_ERR_CODE = 4'h9;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  offset;
        logic [15:0] wdata;
    } decr_cfg_req_t;

    typedef struct packed {
        logic valid;
        logic write;
    } decr_mem_req_t;
endpackage : decr_pkg
`default_nettype wire

/* File: decr_status.sv */
`default_nettype none
module decr_status
    import decr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic sys_err_set,
    input  wire logic mdi_err_set,
    input  wire logic sys_err_clear,
    input  wire logic mdi_clear,
    output logic      signalled_sys_err,
    output logic      master_data_integrity_err
);
    // Set wins over a clear arriving in the same cycle, so no event is lost.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            signalled_sys_err <= 1'b0;
        end else if (sys_err_set) begin
            signalled_sys_err <= 1'b1;
        end else if (sys_err_clear) begin
            signalled_sys_err <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            master_data_integrity_err <= 1'b0;
        end else if (mdi_err_set) begin
            master_data_integrity_err <= 1'b1;
        end else if (mdi_clear) begin
            master_data_integrity_err <= 1'b0;
        end
    end
endmodule : decr_status
`default_nettype wire

/* File: decr_top.sv */
`default_nettype none
module decr_top
    import decr_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire decr_cfg_req_t cfg_req,
    output logic [15:0]        cfg_rdata,
    output logic               cfg_ack,
    input  wire logic          dma_irq_req,
    output logic               legacy_irq,
    input  wire logic [2:0]    engine_err,
    output logic [2:0]         err_pins,
    input  wire logic          parity_err_det,
    output logic               parity_err_report,
    input  wire decr_mem_req_t mem_req,
    output logic               mem_grant,
    output logic               mem_err,
    output logic [3:0]         mem_err_code,
    input  wire logic          mmio_req,
    input  wire logic          mmio_fast_path,
    output logic               mmio_accept,
    output logic               mmio_master_abort,
    input  wire logic          io_req,
    output logic               io_accept
);
    // ------------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------------
    logic [15:0] cmd;
    logic        sys_err_flag;
    logic        mdi;
    logic        cmd_wr;
    logic        sts_wr;
    logic        sys_err_set;
    logic        mdi_set;

    assign cmd_wr = cfg_req.valid && cfg_req.write && (cfg_req.offset == CMD_OFFSET);
    assign sts_wr = cfg_req.valid && cfg_req.write && (cfg_req.offset == STS_OFFSET);
    assign sys_err_set = cmd[SYS_ERR_REP_B] && (engine_err != ERR_NONE);
    assign mdi_set = cmd[PARITY_RESP_B] && parity_err_det;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd <= CMD_RESET;
        end else if (cmd_wr) begin
            // Only writable bits take the value; hardwired and reserved stay zero.
            cmd <= cfg_req.wdata & CMD_WRITE_MASK;
        end
    end

    decr_status u_status (
        .clk                       (clk),
        .rst_b                     (rst_b),
        .sys_err_set               (sys_err_set),
        .mdi_err_set               (mdi_set),
        .sys_err_clear             (sts_wr && cfg_req.wdata[SIG_SYS_ERR_B]),
        .mdi_clear                 (sts_wr && cfg_req.wdata[MDI_ERR_B]),
        .signalled_sys_err         (sys_err_flag),
        .master_data_integrity_err (mdi)
    );

    // ------------------------------------------------------------------
    // Configuration read path
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= 16'h0000;
        end else begin
            cfg_ack <= cfg_req.valid;
            if (cfg_req.valid && !cfg_req.write && cfg_req.offset == CMD_OFFSET) begin
                cfg_rdata <= cmd;
            end else if (cfg_req.valid && !cfg_req.write && cfg_req.offset == STS_OFFSET) begin
                cfg_rdata <= {1'b0, sys_err_flag, 5'b0, mdi, 8'h00};
            end else begin
                cfg_rdata <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Gated outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            legacy_irq <= 1'b0;
        end else begin
            legacy_irq <= dma_irq_req && !cmd[LEGACY_IRQ_OFF_B];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            err_pins          <= ERR_NONE;
            parity_err_report <= 1'b0;
        end else begin
            err_pins          <= cmd[SYS_ERR_REP_B] ? engine_err : ERR_NONE;
            parity_err_report <= parity_err_det && cmd[PARITY_RESP_B];
        end
    end

    // Requests are answered one cycle later; the engine must hold no state on a refusal.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mem_grant    <= 1'b0;
            mem_err      <= 1'b0;
            mem_err_code <= 4'h0;
        end else begin
            mem_grant <= mem_req.valid && cmd[BUS_MASTER_B];
            mem_err   <= mem_req.valid && !cmd[BUS_MASTER_B];
            if (mem_req.valid && !cmd[BUS_MASTER_B]) begin
                mem_err_code <= mem_req.write ? DESC_WRITE_ERR_CODE
                                              : DESC_READ_ERR_CODE;
            end
        end
    end

    // Fast and slow paths abort alike; each path has its own term so neither is missed.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mmio_accept       <= 1'b0;
            mmio_master_abort <= 1'b0;
            io_accept         <= 1'b0;
        end else begin
            mmio_accept       <= mmio_req && cmd[MEM_SPACE_B];
            mmio_master_abort <= !cmd[MEM_SPACE_B] && ((mmio_req && mmio_fast_path)
                                 || (mmio_req && !mmio_fast_path));
            io_accept         <= io_req && cmd[IO_SPACE_B];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_irq_gated: assert property (@(posedge clk) disable iff (!rst_b)
        $past(cmd[LEGACY_IRQ_OFF_B]) |-> !legacy_irq)
        else $error("legacy interrupt while disabled");
    chk_irq_pass: assert property (@(posedge clk) disable iff (!rst_b)
        dma_irq_req && !cmd[LEGACY_IRQ_OFF_B] |=> legacy_irq)
        else $error("legacy interrupt lost while enabled");
    chk_fast_b2b_zero: assert property (@(posedge clk) disable iff (!rst_b)
        !cmd[FAST_B2B_EN_B])
        else $error("fast back-to-back bit set");
    chk_err_pins_off: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(cmd[SYS_ERR_REP_B]) |-> err_pins == ERR_NONE)
        else $error("error pins driven while reporting off");
    chk_err_pins_pass: assert property (@(posedge clk) disable iff (!rst_b)
        cmd[SYS_ERR_REP_B] |=> err_pins == $past(engine_err))
        else $error("error pins do not follow engine error");
    chk_parity_gate: assert property (@(posedge clk) disable iff (!rst_b)
        parity_err_det && cmd[PARITY_RESP_B] |=> parity_err_report)
        else $error("parity error not reported");
    chk_parity_off: assert property (@(posedge clk) disable iff (!rst_b)
        !cmd[PARITY_RESP_B] |=> !parity_err_report)
        else $error("parity error reported while response off");
    chk_mdi_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
        mdi_set |=> mdi)
        else $error("integrity flag not set");
    chk_special_cyc_zero: assert property (@(posedge clk) disable iff (!rst_b)
        !cmd[SPECIAL_CYC_B])
        else $error("special cycle bit set");
    chk_master_grant: assert property (@(posedge clk) disable iff (!rst_b)
        mem_req.valid |=> (mem_grant == $past(cmd[BUS_MASTER_B])))
        else $error("memory grant mismatch");
    chk_master_off: assert property (@(posedge clk) disable iff (!rst_b)
        !cmd[BUS_MASTER_B] |=> !mem_grant)
        else $error("memory granted while mastering off");
    chk_master_refuse: assert property (@(posedge clk) disable iff (!rst_b)
        mem_req.valid && !cmd[BUS_MASTER_B] |=> mem_err
        && mem_err_code == ($past(mem_req.write) ? DESC_WRITE_ERR_CODE
                                                 : DESC_READ_ERR_CODE))
        else $error("missing descriptor error code");
    chk_master_code_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !(mem_req.valid && !cmd[BUS_MASTER_B]) |=> $stable(mem_err_code))
        else $error("error code changed without a refusal");
    chk_mmio_abort: assert property (@(posedge clk) disable iff (!rst_b)
        mmio_req && !cmd[MEM_SPACE_B] |=> mmio_master_abort && !mmio_accept)
        else $error("mmio not aborted");
    chk_mmio_fast_abort: assert property (@(posedge clk) disable iff (!rst_b)
        mmio_req && mmio_fast_path && !cmd[MEM_SPACE_B] |=> mmio_master_abort)
        else $error("fast path mmio not aborted");
    chk_mmio_slow_abort: assert property (@(posedge clk) disable iff (!rst_b)
        mmio_req && !mmio_fast_path && !cmd[MEM_SPACE_B] |=> mmio_master_abort)
        else $error("slow path mmio not aborted");
    chk_mmio_accept: assert property (@(posedge clk) disable iff (!rst_b)
        mmio_req && cmd[MEM_SPACE_B] |=> mmio_accept && !mmio_master_abort)
        else $error("mmio refused while enabled");
    chk_io_never: assert property (@(posedge clk) disable iff (!rst_b)
        !io_accept)
        else $error("legacy io answered");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (cmd & ~CMD_WRITE_MASK) == 16'h0000)
        else $error("reserved bit set");
    chk_cmd_write: assert property (@(posedge clk) disable iff (!rst_b)
        cmd_wr |=> cmd == ($past(cfg_req.wdata) & CMD_WRITE_MASK))
        else $error("command write not taken through mask");
    chk_sys_err_flag: assert property (@(posedge clk) disable iff (!rst_b)
        sys_err_set |=> sys_err_flag)
        else $error("signalled error flag not set");
    chk_sys_err_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        !sys_err_flag && !cmd[SYS_ERR_REP_B] |=> !sys_err_flag)
        else $error("signalled error flag set while reporting off");
    chk_sys_err_clear: assert property (@(posedge clk) disable iff (!rst_b)
        sts_wr && cfg_req.wdata[SIG_SYS_ERR_B] && !sys_err_set |=> !sys_err_flag)
        else $error("signalled error flag not cleared");
    chk_mdi_never: assert property (@(posedge clk) disable iff (!rst_b)
        !mdi && !cmd[PARITY_RESP_B] |=> !mdi)
        else $error("integrity flag set with response off");
endmodule : decr_top
`default_nettype wire

/* File: tb.sv */
`default_nettype none
module tb
    import decr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          clk = 1'b0;
    logic          rst_b = 1'b0;
    decr_cfg_req_t cfg_req;
    logic [15:0]   cfg_rdata;
    logic          cfg_ack, legacy_irq, parity_err_report, mem_grant, mem_err;
    logic          mmio_accept, mmio_master_abort, io_accept;
    logic [2:0]    err_pins;
    logic [3:0]    mem_err_code;
    logic          dma_irq_req = 1'b0, parity_err_det = 1'b0, mmio_req = 1'b0;
    logic          mmio_fast_path = 1'b0, io_req = 1'b0;
    logic [2:0]    engine_err = 3'h0;
    decr_mem_req_t mem_req = '0;
    int            n_fail = 0;
    int            checks_done = 0;

    initial forever #12.5 clk = ~clk;

    decr_host i_host (.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));

    decr_top i_dut (.clk(clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .dma_irq_req(dma_irq_req), .legacy_irq(legacy_irq),
        .engine_err(engine_err), .err_pins(err_pins), .parity_err_det(parity_err_det),
        .parity_err_report(parity_err_report), .mem_req(mem_req), .mem_grant(mem_grant),
        .mem_err(mem_err), .mem_err_code(mem_err_code), .mmio_req(mmio_req),
        .mmio_fast_path(mmio_fast_path), .mmio_accept(mmio_accept),
        .mmio_master_abort(mmio_master_abort), .io_req(io_req), .io_accept(io_accept));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // A missing acknowledge ends the run, since later reads would be meaningless.
    task automatic reg_op(input logic wr, input logic [7:0] off, input logic [15:0] wd,
                          input logic [15:0] exp);
        logic [15:0] rd;
        logic        ok;
        i_host.access(wr, off, wd, rd, ok);
        check("cfg_ack", {15'h0, ok}, 16'h0001);
        if (!ok) finish_test();
        if (!wr) check("cfg_rdata", rd, exp);
    endtask : reg_op

    // Every gated input fires for one cycle; outputs follow one cycle later.
    task automatic step(input logic [15:0] cmd, input logic wr, input logic fast);
        @(negedge clk);
        dma_irq_req = 1'b1;
        engine_err = 3'h5;
        parity_err_det = 1'b1;
        mem_req = '{valid: 1'b1, write: wr};
        mmio_req = 1'b1;
        mmio_fast_path = fast;
        io_req = 1'b1;
        @(negedge clk);
        dma_irq_req = 1'b0;
        engine_err = 3'h0;
        parity_err_det = 1'b0;
        mem_req = '0;
        mmio_req = 1'b0;
        io_req = 1'b0;
        check("legacy_irq", 16'(legacy_irq), 16'(!cmd[10]));
        check("err_pins", 16'(err_pins), cmd[8] ? 16'h0005 : 16'h0000);
        check("parity_err_report", 16'(parity_err_report), 16'(cmd[6]));
        check("mem_grant", 16'(mem_grant), 16'(cmd[2]));
        check("mem_err", 16'(mem_err), 16'(!cmd[2]));
        if (!cmd[2]) check("mem_err_code", 16'(mem_err_code),
            16'(wr ? DESC_WRITE_ERR_CODE : DESC_READ_ERR_CODE));
        check("mmio_accept", 16'(mmio_accept), 16'(cmd[1]));
        check("mmio_master_abort", 16'(mmio_master_abort), 16'(!cmd[1]));
        check("io_accept", 16'(io_accept), 16'h0000);
    endtask : step

    task automatic run_gating(input logic [15:0] cmd);
        reg_op(1'b1, CMD_OFFSET, cmd, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            step(cmd, k[0], k[1]);
        end
    endtask : run_gating

    task automatic test_reset_values();
        reg_op(1'b0, CMD_OFFSET, 16'h0000, 16'h0000);
        reg_op(1'b0, STS_OFFSET, 16'h0000, 16'h0000);
    endtask : test_reset_values

    task automatic test_write_mask();
        reg_op(1'b1, CMD_OFFSET, 16'hFFFF, 16'h0000);
        reg_op(1'b0, CMD_OFFSET, 16'h0000, 16'h0546);
        reg_op(1'b1, 8'h10, 16'hFFFF, 16'h0000);
        reg_op(1'b0, CMD_OFFSET, 16'h0000, 16'h0546);
        reg_op(1'b0, 8'h10, 16'h0000, 16'h0000);
    endtask : test_write_mask

    task automatic test_gating_off();
        run_gating(16'h0000);
        reg_op(1'b0, STS_OFFSET, 16'h0000, 16'h0000);
    endtask : test_gating_off

    // Split enables catch a command bit that steers the wrong output.
    task automatic test_gating_split();
        run_gating(16'h0442);
        reg_op(1'b0, STS_OFFSET, 16'h0000, 16'h0100);
        run_gating(16'h0104);
        check("mem_err_code", 16'(mem_err_code), 16'(DESC_WRITE_ERR_CODE));
        reg_op(1'b0, STS_OFFSET, 16'h0000, 16'h4100);
    endtask : test_gating_split

    task automatic test_status_clear();
        reg_op(1'b1, STS_OFFSET, 16'h4000, 16'h0000);
        reg_op(1'b0, STS_OFFSET, 16'h0000, 16'h0100);
        reg_op(1'b1, STS_OFFSET, 16'h0100, 16'h0000);
        reg_op(1'b0, STS_OFFSET, 16'h0000, 16'h0000);
    endtask : test_status_clear

    task automatic test_gating_on();
        run_gating(16'h0546);
        reg_op(1'b0, STS_OFFSET, 16'h0000, 16'h4100);
    endtask : test_gating_on

    // An engine error in the cycle of the clear must leave the error flag set.
    task automatic test_set_wins();
        fork
            reg_op(1'b1, STS_OFFSET, 16'h4100, 16'h0000);
            begin
                @(negedge clk);
                engine_err = 3'h5;
                @(negedge clk);
                engine_err = 3'h0;
            end
        join
        reg_op(1'b0, STS_OFFSET, 16'h0000, 16'h4000);
        reg_op(1'b1, STS_OFFSET, 16'h4000, 16'h0000);
        reg_op(1'b0, STS_OFFSET, 16'h0000, 16'h0000);
    endtask : test_set_wins

    // A reset in mid-run must drop the command bits and both flags.
    task automatic test_mid_reset();
        step(16'h0546, 1'b1, 1'b1);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        reg_op(1'b0, CMD_OFFSET, 16'h0000, 16'h0000);
        reg_op(1'b0, STS_OFFSET, 16'h0000, 16'h0000);
        step(16'h0000, 1'b0, 1'b0);
    endtask : test_mid_reset

    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        test_reset_values();
        test_write_mask();
        test_gating_off();
        test_gating_split();
        test_status_clear();
        test_gating_on();
        test_set_wins();
        test_mid_reset();
        finish_test();
    end
endmodule : tb
`default_nettype wire
